// *** core/sisp_params.svh ***
`ifndef SISP_PARAMS_SVH
`define SISP_PARAMS_SVH

// clock and self-timed wait figures
`define SISP_CLK_PERIOD_NS      50
`define SISP_FLASH_WAIT_NS      4500000
`define SISP_EEPROM_WAIT_NS     9000000
`define SISP_ERASE_WAIT_NS      9000000
`define SISP_FLASH_WAIT_CYC     ((`SISP_FLASH_WAIT_NS + `SISP_CLK_PERIOD_NS - 1) / `SISP_CLK_PERIOD_NS)
`define SISP_EEPROM_WAIT_CYC    ((`SISP_EEPROM_WAIT_NS + `SISP_CLK_PERIOD_NS - 1) / `SISP_CLK_PERIOD_NS)
`define SISP_ERASE_WAIT_CYC     ((`SISP_ERASE_WAIT_NS + `SISP_CLK_PERIOD_NS - 1) / `SISP_CLK_PERIOD_NS)

// instruction opcodes (byte 1) and sub-codes (byte 2)
`define SISP_OP_ENABLE          8'hAC
`define SISP_SUB_ENABLE         8'h53
`define SISP_SUB_ERASE          8'h80
`define SISP_SUB_WR_LOCK        8'hE0
`define SISP_SUB_WR_FUSE_LO     8'hA0
`define SISP_SUB_WR_FUSE_HI     8'hA8
`define SISP_SUB_WR_FUSE_EXT    8'hA4
`define SISP_OP_POLL            8'hF0
`define SISP_OP_LOAD_EXT        8'h4D
`define SISP_OP_LOAD_LO         8'h40
`define SISP_OP_LOAD_HI         8'h48
`define SISP_OP_WR_PAGE         8'h4C
`define SISP_OP_EE_WR           8'hC0
`define SISP_OP_EE_LOAD         8'hC1
`define SISP_OP_EE_WR_PAGE      8'hC2
`define SISP_OP_RD_LO           8'h20
`define SISP_OP_RD_HI           8'h28
`define SISP_OP_EE_RD           8'hA0
`define SISP_OP_RD_LOCK_FHI     8'h58
`define SISP_OP_RD_FUSE         8'h50
`define SISP_SUB_RD_ALT         8'h08
`define SISP_OP_RD_SIG          8'h30
`define SISP_OP_RD_CAL          8'h38

// reset values: 1 is unprogrammed
`define SISP_LOCK_RST           8'hFF
`define SISP_FUSE_LO_RST        8'hFF
`define SISP_FUSE_HI_RST        8'hFF
`define SISP_FUSE_EXT_RST       8'hFF
`define SISP_EXT_ADDR_RST       8'h00

// field layout of a queued memory command
`define SISP_CMD_DATA_LSB       0
`define SISP_CMD_ADDR_LSB       16
`define SISP_CMD_KIND_LSB       40
`define SISP_CMD_W              42

`endif

// *** core/sisp_pkg.sv ***
package sisp_pkg;
  typedef enum logic [1:0] {
    NVM_FLASH_WORD,
    NVM_EEPROM_BYTE,
    NVM_CHIP_ERASE
  } sisp_nvm_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DUMP_FLASH,
    ST_DUMP_EE,
    ST_PUSH_ONE
  } sisp_state_t;
endpackage : sisp_pkg

// *** core/sisp_fifo.sv ***
`timescale 1ns/100ps
module sisp_fifo #(
  parameter int WIDTH = 42,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             reset_n_in,
  // fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      rd_ptr_q;
  wire              full  = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  wire              empty = (wr_ptr_q == rd_ptr_q);
  wire              push  = in_valid_in && !full;
  wire              pop   = out_ready_in && !empty;

  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = mem_q[rd_ptr_q[AW-1:0]];

  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem_q[wr_ptr_q[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_q + (AW+1)'(push);
      rd_ptr_q <= rd_ptr_q + (AW+1)'(pop);
    end
  end
endmodule : sisp_fifo

// *** core/sisp_engine.sv ***
// Overview of operation
// - sample mosi on rising serial clock
// - drive miso on falling serial clock
// - enable instruction echoes 0x53 during byte three
// - flash page buffer loaded byte by byte
// - 0x40 loads low, 0x48 high byte
// - 0x4c writes buffered page to flash
// - extended address byte kept until reloaded
// - eeprom byte write erases then writes
// - eeprom page load 0xc1, write 0xc2
// - flash read returns byte during byte four
// - eeprom read returns byte during byte four
// - poll returns busy in status bit zero
// - lock, fuse, signature, calibration reads
// - 0xac writes lock and fuse bytes
// - zero is programmed, one unprogrammed
// - accept instructions only while reset pin low
`timescale 1ns/100ps
`include "sisp_params.svh"
module sisp_engine #(
  parameter int         FLASH_WAIT_CYC  = `SISP_FLASH_WAIT_CYC,
  parameter int         EEPROM_WAIT_CYC = `SISP_EEPROM_WAIT_CYC,
  parameter int         ERASE_WAIT_CYC  = `SISP_ERASE_WAIT_CYC,
  parameter int         FIFO_DEPTH      = 16,
  parameter logic [7:0] SIG_BYTE0       = 8'h5A,  // arbitrary identity value
  parameter logic [7:0] SIG_BYTE1       = 8'h01,  // arbitrary identity value
  parameter logic [7:0] SIG_BYTE2       = 8'h02,  // arbitrary identity value
  parameter logic [7:0] CAL_BYTE        = 8'h80
) (
  // clock and reset
  input  wire logic                    sys_clk_in,
  input  wire logic                    reset_n_in,
  // serial programming pins
  input  wire logic                    prog_reset_n_in,
  input  wire logic                    sck_in,
  input  wire logic                    mosi_in,
  output logic                         miso_out,
  // memory read port
  output logic                         nvm_rd_req_out,
  output logic                         nvm_rd_eeprom_out,
  output logic [23:0]                  nvm_rd_addr_out,
  input  wire logic                    nvm_rd_valid_in,
  input  wire logic [15:0]             nvm_rd_data_in,
  // memory write command stream
  output logic                         nvm_wr_valid_out,
  input  wire logic                    nvm_wr_ready_in,
  output sisp_pkg::sisp_nvm_kind_t     nvm_wr_kind_out,
  output logic [23:0]                  nvm_wr_addr_out,
  output logic [15:0]                  nvm_wr_data_out,
  // status and latched fuses
  output logic                         prog_mode_out,
  output logic                         busy_out,
  output logic [7:0]                   lock_bits_out,
  output logic [7:0]                   fuse_low_out,
  output logic [7:0]                   fuse_high_out,
  output logic [7:0]                   fuse_ext_out
);
  import sisp_pkg::*;

  localparam int TW = 18;
  if (FLASH_WAIT_CYC < 1 || FLASH_WAIT_CYC >= (1 << TW) || EEPROM_WAIT_CYC < 1 || EEPROM_WAIT_CYC >= (1 << TW)
      || ERASE_WAIT_CYC < 1 || ERASE_WAIT_CYC >= (1 << TW)) begin : g_bad_wait
    $error("wait counts must lie between 1 and 2**18-1");
  end

  // pin synchronisers: bit 0 reset pin, 1 sck, 2 mosi
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic       sck_prev_q;
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        sync1_q[i] <= 1'b1;
        sync2_q[i] <= 1'b1;
      end else begin
        sync1_q[i] <= (i == 0) ? prog_reset_n_in : (i == 1) ? sck_in : mosi_in;
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  wire pin_high = sync2_q[0];
  wire sck_s    = sync2_q[1];
  wire mosi_s   = sync2_q[2];
  wire sck_rise = sck_s && !sck_prev_q;
  wire sck_fall = !sck_s && sck_prev_q;

  // serial framing state
  logic [2:0]  bit_cnt_q;
  logic [1:0]  byte_idx_q;
  logic [6:0]  in_sr_q;
  logic [7:0]  out_sr_q;
  logic [7:0]  last_rx_q;
  logic [7:0]  b0_q;
  logic [7:0]  b1_q;
  logic [7:0]  b2_q;
  logic        miso_q;
  logic        prog_en_q;
  logic [7:0]  ext_q;
  logic [7:0]  lock_q;
  logic [7:0]  fuse_lo_q;
  logic [7:0]  fuse_hi_q;
  logic [7:0]  fuse_ext_q;
  logic [15:0] rd_data_q;
  logic        rd_req_q;
  logic        rd_ee_q;
  logic [23:0] rd_addr_q;
  logic        busy_q;
  logic [TW-1:0] timer_q;
  sisp_state_t state_q;
  logic [6:0]  dump_cnt_q;
  logic [15:0] cmd_addr_q;
  logic [7:0]  one_data_q;
  sisp_nvm_kind_t one_kind_q;
  logic [7:0]  pbuf_lo_q [128];
  logic [7:0]  pbuf_hi_q [128];
  logic [7:0]  ee_buf_q [8];

  wire [7:0] rx_byte    = {in_sr_q, mosi_s};
  wire       byte_done  = sck_rise && (bit_cnt_q == 3'd7);
  wire       frame_done = byte_done && (byte_idx_q == 2'd3);
  wire       idle       = (state_q == ST_IDLE);

  // decode of the completed instruction
  wire is_enable  = (b0_q == `SISP_OP_ENABLE) && (b1_q == `SISP_SUB_ENABLE);
  wire do_enable  = frame_done && is_enable;
  wire cmd_ok     = frame_done && prog_en_q;
  wire do_erase   = cmd_ok && idle && (b0_q == `SISP_OP_ENABLE) && (b1_q == `SISP_SUB_ERASE);
  wire do_wr_ac   = cmd_ok && (b0_q == `SISP_OP_ENABLE);
  wire do_ext     = cmd_ok && (b0_q == `SISP_OP_LOAD_EXT);
  wire do_load_lo = cmd_ok && (b0_q == `SISP_OP_LOAD_LO);
  wire do_load_hi = cmd_ok && (b0_q == `SISP_OP_LOAD_HI);
  wire do_wr_page = cmd_ok && idle && (b0_q == `SISP_OP_WR_PAGE);
  wire do_ee_wr   = cmd_ok && idle && (b0_q == `SISP_OP_EE_WR);
  wire do_ee_load = cmd_ok && (b0_q == `SISP_OP_EE_LOAD);
  wire do_ee_page = cmd_ok && idle && (b0_q == `SISP_OP_EE_WR_PAGE);

  // read launched as byte three completes, answer needed at byte four
  wire rd_flash = (b0_q == `SISP_OP_RD_LO) || (b0_q == `SISP_OP_RD_HI);
  wire rd_ee    = (b0_q == `SISP_OP_EE_RD);
  wire rd_start = byte_done && (byte_idx_q == 2'd2) && prog_en_q && (rd_flash || rd_ee);
  wire [23:0] rd_addr_d = rd_ee ? {14'h0000, b1_q[1:0], rx_byte} : {ext_q, b1_q, rx_byte};

  // byte-four answer selection
  wire [7:0] sig_byte = (b2_q[3:0] == 4'h0) ? SIG_BYTE0 :
                        (b2_q[3:0] == 4'h1) ? SIG_BYTE1 :
                        (b2_q[3:0] == 4'h2) ? SIG_BYTE2 : 8'hFF;
  wire [7:0] resp =
    (b0_q == `SISP_OP_POLL)                                   ? {7'h00, busy_q} :
    (b0_q == `SISP_OP_RD_LOCK_FHI && b1_q == `SISP_SUB_RD_ALT) ? fuse_hi_q :
    (b0_q == `SISP_OP_RD_LOCK_FHI)                            ? lock_q :
    (b0_q == `SISP_OP_RD_FUSE && b1_q == `SISP_SUB_RD_ALT)    ? fuse_ext_q :
    (b0_q == `SISP_OP_RD_FUSE)                                ? fuse_lo_q :
    (b0_q == `SISP_OP_RD_SIG)                                 ? sig_byte :
    (b0_q == `SISP_OP_RD_CAL)                                 ? CAL_BYTE :
    (b0_q == `SISP_OP_RD_HI)                                  ? rd_data_q[15:8] :
    (rd_flash || rd_ee)                                       ? rd_data_q[7:0] : 8'h00;
  wire [7:0] next_tx = (byte_idx_q == 2'd3 && prog_en_q) ? resp : last_rx_q;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sck_prev_q <= 1'b1;
      bit_cnt_q  <= 3'd0;
      byte_idx_q <= 2'd0;
      in_sr_q    <= 7'h00;
      last_rx_q  <= 8'h00;
    end else begin
      sck_prev_q <= sck_s;
      if (pin_high) begin
        bit_cnt_q  <= 3'd0;
        byte_idx_q <= 2'd0;
      end else if (sck_rise) begin
        in_sr_q   <= rx_byte[6:0];
        bit_cnt_q <= bit_cnt_q + 3'd1;
        if (byte_done) begin
          last_rx_q  <= rx_byte;
          byte_idx_q <= byte_idx_q + 2'd1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      b0_q <= 8'h00;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
    end else if (byte_done && !pin_high) begin
      if (byte_idx_q == 2'd0) b0_q <= rx_byte;
      if (byte_idx_q == 2'd1) b1_q <= rx_byte;
      if (byte_idx_q == 2'd2) b2_q <= rx_byte;
    end
  end

  // outgoing bit changes only on falling sck; echo of the previous byte, or the answer in byte four once enabled
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      miso_q   <= 1'b0;
      out_sr_q <= 8'h00;
    end else if (sck_fall && !pin_high) begin
      if (bit_cnt_q == 3'd0) begin
        miso_q   <= next_tx[7];
        out_sr_q <= {next_tx[6:0], 1'b0};
      end else begin
        miso_q   <= out_sr_q[7];
        out_sr_q <= {out_sr_q[6:0], 1'b0};
      end
    end
  end

  // programming mode, extended address, lock and fuse bytes
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prog_en_q  <= 1'b0;
      ext_q      <= `SISP_EXT_ADDR_RST;
      lock_q     <= `SISP_LOCK_RST;
      fuse_lo_q  <= `SISP_FUSE_LO_RST;
      fuse_hi_q  <= `SISP_FUSE_HI_RST;
      fuse_ext_q <= `SISP_FUSE_EXT_RST;
    end else begin
      if (pin_high) begin
        prog_en_q <= 1'b0;
      end else if (do_enable) begin
        prog_en_q <= 1'b1;
      end
      if (do_ext) ext_q <= b2_q;
      if (do_wr_ac && b1_q == `SISP_SUB_WR_LOCK) lock_q <= rx_byte;
      if (do_wr_ac && b1_q == `SISP_SUB_WR_FUSE_LO) fuse_lo_q <= rx_byte;
      if (do_wr_ac && b1_q == `SISP_SUB_WR_FUSE_HI) fuse_hi_q <= rx_byte;
      if (do_wr_ac && b1_q == `SISP_SUB_WR_FUSE_EXT) fuse_ext_q <= rx_byte;
    end
  end

  // fuses take effect only outside programming mode
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lock_bits_out <= `SISP_LOCK_RST;
      fuse_low_out  <= `SISP_FUSE_LO_RST;
      fuse_high_out <= `SISP_FUSE_HI_RST;
      fuse_ext_out  <= `SISP_FUSE_EXT_RST;
    end else if (!prog_en_q) begin
      lock_bits_out <= lock_q;
      fuse_low_out  <= fuse_lo_q;
      fuse_high_out <= fuse_hi_q;
      fuse_ext_out  <= fuse_ext_q;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_req_q  <= 1'b0;
      rd_ee_q   <= 1'b0;
      rd_addr_q <= 24'h00_0000;
      rd_data_q <= 16'hFFFF;
    end else begin
      rd_req_q <= rd_start;
      if (rd_start) begin
        rd_ee_q   <= rd_ee;
        rd_addr_q <= rd_addr_d;
      end
      if (nvm_rd_valid_in) rd_data_q <= nvm_rd_data_in;
    end
  end

  // page buffers hold data only, no reset
  always_ff @(posedge sys_clk_in) begin
    if (do_load_lo) pbuf_lo_q[b2_q[6:0]] <= rx_byte;
    if (do_load_hi) pbuf_hi_q[b2_q[6:0]] <= rx_byte;
    if (do_ee_load) ee_buf_q[b2_q[2:0]] <= rx_byte;
  end

  // write sequencer feeding the command fifo
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [`SISP_CMD_W-1:0] fifo_out_data;
  wire        push_valid = !idle;
  wire        push_ok    = push_valid && fifo_in_ready;
  wire        dump_last  = (state_q == ST_DUMP_FLASH) ? (dump_cnt_q == 7'd127) : (dump_cnt_q == 7'd7);
  wire [23:0] push_addr  =
    (state_q == ST_DUMP_FLASH) ? {ext_q, cmd_addr_q[15:7], dump_cnt_q} :
    (state_q == ST_DUMP_EE)    ? {8'h00, cmd_addr_q[15:3], dump_cnt_q[2:0]} : {8'h00, cmd_addr_q};
  wire [15:0] push_data  =
    (state_q == ST_DUMP_FLASH) ? {pbuf_hi_q[dump_cnt_q], pbuf_lo_q[dump_cnt_q]} :
    (state_q == ST_DUMP_EE)    ? {8'h00, ee_buf_q[dump_cnt_q[2:0]]} : {8'h00, one_data_q};
  wire [1:0]  push_kind  =
    (state_q == ST_DUMP_FLASH) ? NVM_FLASH_WORD : (state_q == ST_DUMP_EE) ? NVM_EEPROM_BYTE : one_kind_q;
  wire [TW-1:0] wait_load =
    (state_q == ST_DUMP_FLASH) ? TW'(FLASH_WAIT_CYC) :
    (one_kind_q == NVM_CHIP_ERASE && state_q == ST_PUSH_ONE) ? TW'(ERASE_WAIT_CYC) : TW'(EEPROM_WAIT_CYC);
  wire        seq_end    = push_ok && (state_q == ST_PUSH_ONE || dump_last);

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q    <= ST_IDLE;
      dump_cnt_q <= 7'd0;
      cmd_addr_q <= 16'h0000;
      one_data_q <= 8'h00;
      one_kind_q <= NVM_EEPROM_BYTE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          dump_cnt_q <= 7'd0;
          cmd_addr_q <= {b1_q, b2_q};
          one_data_q <= rx_byte;
          if (do_wr_page) begin
            state_q <= ST_DUMP_FLASH;
          end else if (do_ee_page) begin
            state_q <= ST_DUMP_EE;
          end else if (do_ee_wr) begin
            state_q    <= ST_PUSH_ONE;
            one_kind_q <= NVM_EEPROM_BYTE;
          end else if (do_erase) begin
            state_q    <= ST_PUSH_ONE;
            one_kind_q <= NVM_CHIP_ERASE;
          end
        end
        ST_DUMP_FLASH, ST_DUMP_EE, ST_PUSH_ONE: begin
          if (seq_end) begin
            state_q <= ST_IDLE;
          end else if (push_ok) begin
            dump_cnt_q <= dump_cnt_q + 7'd1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // self-timed wait and busy flag
  wire busy_d = (timer_q != '0) || !idle || fifo_out_valid;
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      timer_q <= '0;
      busy_q  <= 1'b0;
    end else begin
      busy_q <= busy_d;
      if (seq_end) begin
        timer_q <= wait_load;
      end else if (timer_q != '0) begin
        timer_q <= timer_q - TW'(1);
      end
    end
  end

  sisp_fifo #(
    .WIDTH (`SISP_CMD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_cmd_fifo (
    .sys_clk_in    (sys_clk_in),
    .reset_n_in    (reset_n_in),
    .in_valid_in   (push_valid),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    ({push_kind, push_addr, push_data}),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (nvm_wr_ready_in),
    .out_data_out  (fifo_out_data)
  );

  assign miso_out          = miso_q;
  assign nvm_rd_req_out    = rd_req_q;
  assign nvm_rd_eeprom_out = rd_ee_q;
  assign nvm_rd_addr_out   = rd_addr_q;
  assign nvm_wr_valid_out  = fifo_out_valid;
  assign nvm_wr_kind_out   = sisp_nvm_kind_t'(fifo_out_data[`SISP_CMD_KIND_LSB+:2]);
  assign nvm_wr_addr_out   = fifo_out_data[`SISP_CMD_ADDR_LSB+:24];
  assign nvm_wr_data_out   = fifo_out_data[`SISP_CMD_DATA_LSB+:16];
  assign prog_mode_out     = prog_en_q;
  assign busy_out          = busy_q;

  property p_sample_on_rise;
    @(posedge sys_clk_in) disable iff (!reset_n_in) (bit_cnt_q != $past(bit_cnt_q)) && !$past(pin_high)
      |-> $past(sck_rise);
  endproperty
  a_sample_on_rise: assert property (p_sample_on_rise) else $error("bit count moved without rising sck");

  property p_drive_on_fall;
    @(posedge sys_clk_in) disable iff (!reset_n_in) $changed(miso_q) |-> $past(sck_fall);
  endproperty
  a_drive_on_fall: assert property (p_drive_on_fall) else $error("miso changed without falling sck");

  property p_enable_echo;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      sck_fall && !pin_high && bit_cnt_q == 3'd0 && byte_idx_q == 2'd2 && last_rx_q == `SISP_SUB_ENABLE
      |=> miso_q == 1'b0 ##0 out_sr_q == 8'hA6;
  endproperty
  a_enable_echo: assert property (p_enable_echo) else $error("enable echo byte wrong");

  property p_mode_exit;
    @(posedge sys_clk_in) disable iff (!reset_n_in) pin_high |=> !prog_en_q && byte_idx_q == 2'd0;
  endproperty
  a_mode_exit: assert property (p_mode_exit) else $error("programming mode kept with reset pin high");

  property p_ext_hold;
    @(posedge sys_clk_in) disable iff (!reset_n_in) !do_ext |=> $stable(ext_q);
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("extended address changed without load");

  property p_erase_busy;
    @(posedge sys_clk_in) disable iff (!reset_n_in) do_erase |=> ##1 busy_q [*8];
  endproperty
  a_erase_busy: assert property (p_erase_busy) else $error("chip erase did not report busy");

  property p_poll_answer;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      sck_fall && !pin_high && bit_cnt_q == 3'd0 && byte_idx_q == 2'd3 && prog_en_q && b0_q == `SISP_OP_POLL
      |=> miso_q == 1'b0 && out_sr_q == {6'h00, $past(busy_q), 1'b0};
  endproperty
  a_poll_answer: assert property (p_poll_answer) else $error("poll answer differs from busy");

  property p_page_length;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      state_q == ST_DUMP_FLASH && push_ok && dump_cnt_q == 7'd127 |=> state_q == ST_IDLE && timer_q != '0;
  endproperty
  a_page_length: assert property (p_page_length) else $error("flash page write did not end at word 127");

  property p_low_before_busy_end;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      seq_end && state_q == ST_DUMP_FLASH |=> timer_q == TW'(FLASH_WAIT_CYC) && busy_q;
  endproperty
  a_low_before_busy_end: assert property (p_low_before_busy_end) else $error("flash wait not started after page");

  c_enable: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in) do_enable);
  c_page_write: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in) do_wr_page);
  c_fifo_full: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in) push_valid && !fifo_in_ready);
  c_read: cover property (@(posedge sys_clk_in) disable iff (!reset_n_in) rd_start);
endmodule : sisp_engine

// *** tb/sisp_prog.sv ***
`timescale 1ns/100ps
module sisp_prog (
  // serial link
  input  wire logic sys_clk_in,
  output logic      sck_out,
  output logic      mosi_out,
  input  wire logic miso_in
);
  initial begin
    sck_out  = 1'b0;
    mosi_out = 1'b0;
  end
  // four bytes msb first, each phase four clocks
  task automatic xfer(input logic [31:0] cmd, output logic [31:0] rx);
    for (int i = 31; i >= 0; i--) begin
      mosi_out = cmd[i];
      repeat (4) @(negedge sys_clk_in);
      sck_out = 1'b1;
      rx[i]   = miso_in;
      repeat (4) @(negedge sys_clk_in);
      sck_out = 1'b0;
    end
    mosi_out = ~mosi_out;
    @(negedge sys_clk_in);
  endtask : xfer
endmodule : sisp_prog

// *** tb/serial_isp_command_engine_test.sv ***
`timescale 1ns/100ps
module serial_isp_command_engine_test;
  import sisp_pkg::*;
  typedef struct {sisp_nvm_kind_t k; logic [23:0] a; logic [15:0] d; logic c;} sisp_exp_t;
  logic           sys_clk_in = 1'b0, reset_n_in = 1'b0, prog_reset_n_in = 1'b0;
  logic           sck, mosi, miso, rd_req, rd_ee, rd_valid = 1'b0, wr_valid, wr_ready = 1'b0;
  logic           prog_mode, busy, stall = 1'b1;
  logic [23:0]    rd_addr, wr_addr;
  logic [15:0]    rd_data = 16'h0000, wr_data;
  logic [7:0]     lock_v, flo, fhi, fext, v[4];
  logic [7:0]     sub[4] = '{8'hA0, 8'hE0, 8'hA8, 8'hA4};
  logic [31:0]    rdc[4] = '{32'h5000_0000, 32'h5800_0000, 32'h5808_0000, 32'h5008_0000};
  logic [31:0]    rx;
  sisp_nvm_kind_t wr_kind;
  sisp_exp_t      expq[$];
  sisp_exp_t      e;
  int             n_fail = 0, checked = 0, seed = 39443, rd_cnt = 0;
  always #25 sys_clk_in = ~sys_clk_in;
  sisp_engine #(.FLASH_WAIT_CYC(20), .EEPROM_WAIT_CYC(20), .ERASE_WAIT_CYC(20)) i_sisp_engine (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .prog_reset_n_in(prog_reset_n_in), .sck_in(sck),
    .mosi_in(mosi), .miso_out(miso), .nvm_rd_req_out(rd_req), .nvm_rd_eeprom_out(rd_ee),
    .nvm_rd_addr_out(rd_addr), .nvm_rd_valid_in(rd_valid), .nvm_rd_data_in(rd_data),
    .nvm_wr_valid_out(wr_valid), .nvm_wr_ready_in(wr_ready), .nvm_wr_kind_out(wr_kind),
    .nvm_wr_addr_out(wr_addr), .nvm_wr_data_out(wr_data), .prog_mode_out(prog_mode), .busy_out(busy),
    .lock_bits_out(lock_v), .fuse_low_out(flo), .fuse_high_out(fhi), .fuse_ext_out(fext));
  sisp_prog i_sisp_prog (.sys_clk_in(sys_clk_in), .sck_out(sck), .mosi_out(mosi), .miso_in(miso));
  // memory: read answers next cycle, write sink stalls at random
  always @(negedge sys_clk_in) begin
    rd_valid <= rd_req;
    rd_cnt   <= rd_cnt + int'(rd_req === 1'b1);
    rd_data  <= rd_addr[15:0] ^ {rd_addr[23:16], 8'h5C};
    wr_ready <= !stall && ($random(seed) % 2 != 0);
  end
  task automatic cmp(input string what, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  always @(posedge sys_clk_in) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      if (expq.size() == 0) cmp("wr_extra", 24'h0, 24'h1);
      else begin
        e = expq.pop_front();
        cmp("wr_kind", e.k, wr_kind);
        if (e.k !== NVM_CHIP_ERASE) cmp("wr_addr", e.a, wr_addr);
        if (e.c) cmp("wr_data", e.d, (e.k === NVM_FLASH_WORD) ? wr_data : {8'h00, wr_data[7:0]});
      end
    end
  end
  task automatic sx(input logic [31:0] c);
    i_sisp_prog.xfer(c, rx);
  endtask : sx
  task automatic wait_idle;
    for (int k = 0; k < 20; k++) begin
      sx(32'hF000_0000);
      if (rx[0] === 1'b0) break;
    end
    cmp("busy", 24'h0, rx[0]);
  endtask : wait_idle
  task automatic wrap_up;
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (60000) @(posedge sys_clk_in);
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (2) @(negedge sys_clk_in);
    reset_n_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    cmp("fuse_rst", 24'hFF_FFFF, {lock_v, flo, fhi});
    cmp("fext_rst", 24'hFF, fext);
    sx(32'h2000_0000);
    cmp("locked_rd", 24'h0, 24'(rd_cnt));
    sx(32'hAC53_0000);
    cmp("echo", 24'h53, rx[15:8]);
    cmp("prog_mode", 24'h1, prog_mode);
    $display("enable done");
    for (int i = 0; i < 4; i++) begin
      v[i] = 8'($random(seed));
      sx({8'hAC, sub[i], 8'h00, v[i]});
    end
    for (int i = 0; i < 4; i++) begin
      sx(rdc[i]);
      cmp("fuse_rd", v[i], rx[7:0]);
    end
    sx(32'h3000_0000);
    cmp("sig", 24'h5A, rx[7:0]);
    sx(32'h3800_0000);
    cmp("cal", 24'h80, rx[7:0]);
    $display("fuse done");
    sx(32'h4D00_0300);
    sx(32'h2012_3400);
    cmp("rd_lo", 8'h34 ^ 8'h5C, rx[7:0]);
    sx(32'h2812_3400);
    cmp("rd_hi", 8'h12 ^ 8'h03, rx[7:0]);
    sx(32'hA001_2300);
    cmp("ee_rd", 8'h23 ^ 8'h5C, rx[7:0]);
    cmp("rd_ee", 24'h1, rd_ee);
    cmp("rd_addr", 24'h00_0123, rd_addr);
    cmp("rd_cnt", 24'h3, 24'(rd_cnt));
    $display("read done");
    sx(32'h4000_0011);
    sx(32'h4800_0022);
    sx(32'h4000_7F33);
    sx(32'h4800_7F44);
    for (int w = 0; w < 128; w++)
      expq.push_back('{NVM_FLASH_WORD, {16'h0312, 1'b1, w[6:0]}, (w == 0) ? 16'h2211 : 16'h4433, w == 0 || w == 127});
    sx(32'h4C12_8000);
    sx(32'hF000_0000);
    cmp("busy_set", 24'h1, rx[0]);
    cmp("busy_out", 24'h1, busy);
    stall = 1'b0;
    wait_idle();
    $display("page done");
    expq.push_back('{NVM_EEPROM_BYTE, 24'h00_0123, 16'h0066, 1'b1});
    sx(32'hC001_2366);
    wait_idle();
    sx(32'hC100_0277);
    for (int i = 0; i < 8; i++)
      expq.push_back('{NVM_EEPROM_BYTE, {16'h0000, 5'h08, i[2:0]}, 16'h0077, i == 2});
    sx(32'hC200_4000);
    wait_idle();
    expq.push_back('{NVM_CHIP_ERASE, 24'h0, 16'h0, 1'b0});
    sx(32'hAC80_0000);
    wait_idle();
    cmp("wr_left", 24'h0, 24'(expq.size()));
    cmp("busy_idle", 24'h0, busy);
    $display("write done");
    prog_reset_n_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    cmp("prog_exit", 24'h0, prog_mode);
    cmp("fuse_out", {v[1], v[0], v[2]}, {lock_v, flo, fhi});
    cmp("fext_out", v[3], fext);
    wrap_up();
  end
endmodule : serial_isp_command_engine_test
